// ---- include/result_status_pkg.sv ----
// Package for the result-phase status byte block.
// Assumes one 100 MHz controller clock shared with the rest of the core.
package result_status_pkg;

  // ----------------------------------------------------------------
  // Transfer error byte fields
  // ----------------------------------------------------------------
  localparam int TE_END_OF_TRACK = 7;
  localparam int TE_CRC_ANY = 5;
  localparam int TE_SERVICE_LATE = 4;
  localparam int TE_SECTOR_MISSING = 2;
  localparam int TE_WRITE_BLOCKED = 1;
  localparam int TE_ADDR_SYNC = 0;

  // ----------------------------------------------------------------
  // Address mark byte fields
  // ----------------------------------------------------------------
  localparam int AM_TYPE_MISMATCH = 6;
  localparam int AM_PAYLOAD_CRC = 5;
  localparam int AM_TRACK_MISMATCH = 4;
  localparam int AM_BAD_TRACK = 1;
  localparam int AM_PAYLOAD_SYNC = 0;

  // ----------------------------------------------------------------
  // Drive line byte fields
  // ----------------------------------------------------------------
  localparam int DL_WRITE_PROT = 6;
  localparam int DL_ONE_HI = 5;
  localparam int DL_OUTER_TRACK = 4;
  localparam int DL_ONE_LO = 3;
  localparam int DL_HEAD = 2;
  localparam int DL_DRIVE_HI = 1;
  localparam int DL_DRIVE_LO = 0;

  // ----------------------------------------------------------------
  // Values
  // ----------------------------------------------------------------
  localparam logic [7:0] BAD_TRACK_VALUE = 8'hff;
  localparam logic [7:0] LAST_SECTOR_LIMIT = 8'hff;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [1:0] INDEX_PASS_LIMIT = 2'h2;

  // Result byte selector, in the order the host reads them
  localparam logic [1:0] SEL_TRANSFER = 2'h0;
  localparam logic [1:0] SEL_MARK = 2'h1;
  localparam logic [1:0] SEL_DRIVE = 2'h2;

  // Command classes supplied by the sequencer
  typedef enum logic [2:0] {
    CMD_OTHER = 3'h0,
    CMD_READ_DATA = 3'h1,
    CMD_READ_DELETED = 3'h2,
    CMD_WRITE_DATA = 3'h3,
    CMD_WRITE_DELETED = 3'h4,
    CMD_FORMAT = 3'h5,
    CMD_READ_ID = 3'h6,
    CMD_READ_TRACK = 3'h7
  } cmd_class_type;

  // Forced write-protect configuration
  typedef enum logic [1:0] {
    WP_PIN = 2'h0,
    WP_FORCE_ON = 2'h1,
    WP_FORCE_OFF = 2'h2
  } wp_force_type;

  typedef enum logic [2:0] {
    PH_IDLE = 3'b001,
    PH_EXEC = 3'b010,
    PH_RESULT = 3'b100
  } phase_type;

endpackage

// ---- rtl/result_status.sv ----
// Result-phase status bytes: transfer errors, address marks, drive lines.
// Assumes the sequencer supplies command class, compare results and strobes
// on clk_sys; drive pins arrive asynchronously and are synchronised here.
`timescale 1ns/100ps

module result_status
  import result_status_pkg::*;
#(
  // Highest sector number; stepping on from it runs off the track
  parameter logic [7:0] FINAL_SECTOR = LAST_SECTOR_LIMIT,
  // Index rise count at which a missing ID mark is flagged
  parameter logic [1:0] INDEX_PASSES = INDEX_PASS_LIMIT
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  // Command flow
  input wire logic cmd_start,
  input wire cmd_class_type cmd_class,
  input wire logic exec_done,
  input wire logic result_done,
  // Sector and track compare
  input wire logic [7:0] sector_number,
  input wire logic sector_step,
  input wire logic [7:0] id_track,
  input wire logic [7:0] internal_track,
  input wire logic id_valid,
  // Error strobes
  input wire logic id_crc_fail,
  input wire logic data_crc_fail,
  input wire logic service_timeout,
  input wire logic sector_not_found,
  input wire logic id_read_fail,
  input wire logic sequence_fail,
  // Address marks
  input wire logic id_sync_seen,
  input wire logic data_mark_seen,
  input wire logic deleted_mark_seen,
  input wire logic data_mark_timeout,
  // Configuration
  input wire logic [1:0] wp_force,
  // Drive lines
  input wire logic write_protect_input,
  input wire logic outer_track_input,
  input wire logic index_pulse_input,
  input wire logic terminal_count_input,
  input wire logic side_select_output,
  input wire logic [1:0] drive_select_output,
  // Data register read port
  input wire logic result_read,
  output logic [7:0] result_data,
  output logic result_valid,
  output logic [7:0] transfer_error_status,
  output logic [7:0] address_mark_status
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    // Pin synchroniser stages
    logic wp_s1;
    logic wp_s2;
    logic t0_s1;
    logic t0_s2;
    logic idx_s1;
    logic idx_s2;
    logic tc_s1;
    logic tc_s2;
    logic idx_prev;
    logic wp_prev;
    logic tc_seen;
    logic [1:0] idx_count;
    phase_type phase;
    logic [1:0] sel;
    logic [7:0] te;
    logic [7:0] am;
    logic [7:0] data;
    logic valid;
  } state_type;

  state_type s_q, s_d;

  // Only the second stage of each synchroniser is read by logic
  logic wp_sync, t0_sync, idx_sync, tc_sync;
  assign wp_sync = s_q.wp_s2;
  assign t0_sync = s_q.t0_s2;
  assign idx_sync = s_q.idx_s2;
  assign tc_sync = s_q.tc_s2;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic is_write_cmd(input cmd_class_type c);
    return (c == CMD_WRITE_DATA) || (c == CMD_WRITE_DELETED) || (c == CMD_FORMAT);
  endfunction

  function automatic logic is_data_cmd(input cmd_class_type c);
    return (c == CMD_READ_DATA) || (c == CMD_READ_DELETED) ||
           (c == CMD_WRITE_DATA) || (c == CMD_WRITE_DELETED);
  endfunction

  // Forced settings override the pin either way
  function automatic logic wp_effective(input logic pin, input logic [1:0] f);
    case (f)
      WP_FORCE_ON: return 1'b1;
      WP_FORCE_OFF: return 1'b0;
      default: return pin;
    endcase
  endfunction

  function automatic logic [7:0] drive_byte(input logic wp, input logic t0,
                                            input logic hd, input logic [1:0] ds);
    logic [7:0] b;
    b = BYTE_ZERO;
    b[DL_WRITE_PROT] = wp;
    b[DL_ONE_HI] = 1'b1;
    b[DL_OUTER_TRACK] = t0;
    b[DL_ONE_LO] = 1'b1;
    b[DL_HEAD] = hd;
    b[DL_DRIVE_HI] = ds[1];
    b[DL_DRIVE_LO] = ds[0];
    return b;
  endfunction

  function automatic logic is_read_cmd(input cmd_class_type c);
    return (c == CMD_READ_DATA) || (c == CMD_READ_DELETED);
  endfunction

  // Each not-found case only counts for its own command
  function automatic logic missing_event(input cmd_class_type c, input logic sector_nf,
                                         input logic id_fail, input logic seq_fail);
    logic hit;
    hit = sector_nf && is_read_cmd(c);
    hit = hit || (id_fail && (c == CMD_READ_ID));
    hit = hit || (seq_fail && (c == CMD_READ_TRACK));
    return hit;
  endfunction

  // Deleted mark on a plain read, or plain mark on a deleted read
  function automatic logic mark_mismatch(input cmd_class_type c, input logic plain,
                                         input logic deleted);
    return ((c == CMD_READ_DATA) && deleted) || ((c == CMD_READ_DELETED) && plain);
  endfunction

  // Selector walks transfer, mark, drive and then parks on the live drive byte
  function automatic logic [1:0] next_sel(input logic [1:0] sel);
    logic [1:0] n;
    n = sel;
    if (sel != SEL_DRIVE) begin
      n = sel + 2'h1;
    end
    return n;
  endfunction

  // Nothing leaks onto the data register outside the result phase
  function automatic logic [7:0] result_byte(input logic show, input logic [1:0] sel,
                                             input logic [7:0] te, input logic [7:0] am,
                                             input logic [7:0] dl);
    logic [7:0] b;
    case (sel)
      SEL_TRANSFER: b = te;
      SEL_MARK: b = am;
      default: b = dl;
    endcase
    if (!show) begin
      b = BYTE_ZERO;
    end
    return b;
  endfunction

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    logic wp_eff;
    logic idx_rise;
    logic start_ok;
    logic capture;
    logic [7:0] dl_byte;
    wp_eff = 1'b0;
    idx_rise = 1'b0;
    start_ok = 1'b0;
    capture = 1'b0;
    dl_byte = BYTE_ZERO;
    s_d = s_q;

    // --------------------------------------------------------------
    // Pin synchronisers and edge history
    // --------------------------------------------------------------
    s_d.wp_s1 = write_protect_input;
    s_d.wp_s2 = s_q.wp_s1;
    s_d.t0_s1 = outer_track_input;
    s_d.t0_s2 = s_q.t0_s1;
    s_d.idx_s1 = index_pulse_input;
    s_d.idx_s2 = s_q.idx_s1;
    s_d.tc_s1 = terminal_count_input;
    s_d.tc_s2 = s_q.tc_s1;
    s_d.idx_prev = idx_sync;
    wp_eff = wp_effective(wp_sync, wp_force);
    s_d.wp_prev = wp_eff;
    idx_rise = idx_sync && !s_q.idx_prev;

    // --------------------------------------------------------------
    // Phase sequencing
    // --------------------------------------------------------------
    // Start is only taken from idle, so a stray one cannot wipe live errors
    start_ok = cmd_start && (s_q.phase == PH_IDLE);
    capture = (s_q.phase == PH_EXEC);
    case (s_q.phase)
      PH_IDLE: begin
        if (start_ok) begin
          s_d.phase = PH_EXEC;
        end
      end
      PH_EXEC: begin
        if (exec_done) begin
          s_d.phase = PH_RESULT;
          s_d.sel = SEL_TRANSFER;
        end
      end
      PH_RESULT: begin
        if (result_done) begin
          s_d.phase = PH_IDLE;
        end else if (result_read) begin
          s_d.sel = next_sel(s_q.sel);
        end
      end
      default: s_d.phase = PH_IDLE;
    endcase

    // --------------------------------------------------------------
    // Transfer error capture
    // --------------------------------------------------------------
    // New command clears, so stale errors never leak
    if (start_ok) begin
      s_d.te = BYTE_ZERO;
      s_d.tc_seen = 1'b0;
      s_d.idx_count = 2'h0;
    end else if (capture) begin
      if (tc_sync) begin
        s_d.tc_seen = 1'b1;
      end
      if (sector_step && sector_number == FINAL_SECTOR) begin
        s_d.te[TE_END_OF_TRACK] = 1'b1;
      end
      if (exec_done && is_data_cmd(cmd_class) && !s_q.tc_seen && !tc_sync) begin
        s_d.te[TE_END_OF_TRACK] = 1'b1;
      end
      if (id_crc_fail || data_crc_fail) begin
        s_d.te[TE_CRC_ANY] = 1'b1;
      end
      if (service_timeout) begin
        s_d.te[TE_SERVICE_LATE] = 1'b1;
      end
      if (missing_event(cmd_class, sector_not_found, id_read_fail, sequence_fail)) begin
        s_d.te[TE_SECTOR_MISSING] = 1'b1;
      end
      if (is_write_cmd(cmd_class) && wp_eff && !s_q.wp_prev) begin
        s_d.te[TE_WRITE_BLOCKED] = 1'b1;
      end
      if (id_sync_seen) begin
        s_d.idx_count = 2'h0;
      end else if (idx_rise && s_q.idx_count != INDEX_PASSES) begin
        s_d.idx_count = s_q.idx_count + 2'h1;
      end
      if (!id_sync_seen && idx_rise && s_q.idx_count + 2'h1 == INDEX_PASSES) begin
        s_d.te[TE_ADDR_SYNC] = 1'b1;
      end
      if (data_mark_timeout) begin
        s_d.te[TE_ADDR_SYNC] = 1'b1;
      end
    end

    // --------------------------------------------------------------
    // Address mark capture
    // --------------------------------------------------------------
    if (start_ok) begin
      s_d.am = BYTE_ZERO;
    end else if (capture) begin
      if (data_mark_timeout) begin
        s_d.am[AM_PAYLOAD_SYNC] = 1'b1;
      end
      if (mark_mismatch(cmd_class, data_mark_seen, deleted_mark_seen)) begin
        s_d.am[AM_TYPE_MISMATCH] = 1'b1;
      end
      if (data_crc_fail) begin
        s_d.am[AM_PAYLOAD_CRC] = 1'b1;
      end
      if (id_valid && id_track != internal_track) begin
        s_d.am[AM_TRACK_MISMATCH] = 1'b1;
        if (id_track == BAD_TRACK_VALUE) begin
          s_d.am[AM_BAD_TRACK] = 1'b1;
        end
      end
    end

    // --------------------------------------------------------------
    // Result byte view
    // --------------------------------------------------------------
    // Drive byte follows the pins live; the error bytes are frozen by now
    s_d.valid = (s_d.phase == PH_RESULT);
    dl_byte = drive_byte(wp_eff, t0_sync, side_select_output, drive_select_output);
    s_d.data = result_byte(s_d.valid, s_d.sel, s_d.te, s_d.am, dl_byte);
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      s_q <= '{phase: PH_IDLE, default: '0};
    end else begin
      s_q <= s_d;
    end
  end

  assign result_data = s_q.data;
  assign result_valid = s_q.valid;
  assign transfer_error_status = s_q.te;
  assign address_mark_status = s_q.am;

endmodule // result_status

// ---- verif/result_status_props.sv ----
// Assertion checker for result_status, bound at the foot.
// Assumes one clock and the order start, pulses, done, reads.
`timescale 1ns/100ps

module result_status_props
  import result_status_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  // Sequencer
  input wire logic cmd_start,
  input wire logic exec_done,
  input wire logic result_read,
  input wire logic id_valid,
  input wire logic [7:0] id_track,
  input wire logic [7:0] internal_track,
  input wire logic id_crc_fail,
  input wire logic data_crc_fail,
  // Status outputs
  input wire logic [7:0] result_data,
  input wire logic result_valid,
  input wire logic [7:0] transfer_error_status,
  input wire logic [7:0] address_mark_status
);
  // Shadow of the execution phase; start only counts from idle
  logic exec_q;
  logic bad_id;
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) exec_q <= 1'b0;
    else if (exec_done) exec_q <= 1'b0;
    else if (cmd_start && !result_valid) exec_q <= 1'b1;
  end
  assign bad_id = exec_q && id_valid && id_track != internal_track;

  default clocking @(posedge clk_sys); endclocking
  default disable iff (!reset_n);

  unused_zero_a: assert property (transfer_error_status[6] == 1'b0
    && transfer_error_status[3] == 1'b0 && address_mark_status[7] == 1'b0
    && address_mark_status[3:2] == 2'h0) else $error("unused bit set");
  crc_any_a: assert property (exec_q && (id_crc_fail || data_crc_fail)
    |=> transfer_error_status[TE_CRC_ANY]) else $error("crc bit missing");
  payload_crc_a: assert property (exec_q && data_crc_fail
    |=> address_mark_status[AM_PAYLOAD_CRC]) else $error("data crc bit missing");
  track_diff_a: assert property (bad_id
    |=> address_mark_status[AM_TRACK_MISMATCH]) else $error("track bit missing");
  bad_track_a: assert property (bad_id && id_track == BAD_TRACK_VALUE
    |=> address_mark_status[AM_BAD_TRACK]) else $error("bad track bit missing");
  new_clear_a: assert property (cmd_start && !exec_q && !result_valid
    |=> transfer_error_status == 8'h00 && address_mark_status == 8'h00)
    else $error("errors not cleared");
  first_byte_a: assert property (exec_q && exec_done
    |=> result_valid && result_data == transfer_error_status) else $error("first byte wrong");
  drive_fixed_a: assert property (exec_q && exec_done ##3 result_read ##3 result_read
    |=> result_data[5] && result_data[3] && !result_data[7]) else $error("fixed bits wrong");

  cover property (exec_done ##3 result_read);
  cover property (transfer_error_status[TE_END_OF_TRACK]);
  cover property (address_mark_status[AM_BAD_TRACK]);
endmodule // result_status_props

bind result_status result_status_props result_status_props_i (.*);

// ---- verif/drive_model.sv ----
// Floppy drive line model: write-protect, outer track, index.
// Assumes the bench sets levels and spin; index idles low.
`timescale 1ns/100ps

module drive_model (
  // Clock and controls
  input wire logic clk_sys,
  input wire logic spin,
  input wire logic wp_level,
  input wire logic trk_level,
  // Drive lines
  output logic write_protect_input,
  output logic outer_track_input,
  output logic index_pulse_input
);
  // Index every 16 clocks, two wide; far shorter than a real turn
  logic [3:0] ang_q;
  always_ff @(posedge clk_sys) begin
    ang_q <= spin ? ang_q + 4'h1 : 4'h0;
  end
  assign index_pulse_input = spin && ang_q[3:1] == 3'h7;
  assign write_protect_input = wp_level;
  assign outer_track_input = trk_level;
endmodule // drive_model

// ---- verif/tb_top.sv ----
// Self-checking bench for the result status block.
// Assumes drive_model on the drive pins and the bound checker.
`timescale 1ns/100ps

module tb_top import result_status_pkg::*;;
  logic clk_sys = 1'b0;
  logic reset_n = 1'b0;
  logic [15:0] p = 16'h0000;
  cmd_class_type cmd_class = CMD_OTHER;
  logic [7:0] sector_number = 8'h01, id_track = 8'h03, internal_track = 8'h03;
  logic [1:0] wp_force = 2'h0, drive_select_output = 2'h0;
  logic terminal_count_input = 1'b0, side_select_output = 1'b0;
  logic spin = 1'b0, wp_level = 1'b0, trk_level = 1'b0;
  logic write_protect_input, outer_track_input, index_pulse_input, result_valid;
  logic [7:0] result_data, transfer_error_status, address_mark_status;
  int bad_count = 0;
  int check_count = 0;

  always #5 clk_sys = ~clk_sys;

  result_status result_status_i (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .cmd_start(p[15]),
    .cmd_class(cmd_class),
    .exec_done(p[14]),
    .result_done(p[13]),
    .sector_number(sector_number),
    .sector_step(p[9]),
    .id_track(id_track),
    .internal_track(internal_track),
    .id_valid(p[11]),
    .id_crc_fail(p[8]),
    .data_crc_fail(p[7]),
    .service_timeout(p[6]),
    .sector_not_found(p[5]),
    .id_read_fail(p[4]),
    .sequence_fail(p[3]),
    .id_sync_seen(p[10]),
    .data_mark_seen(p[2]),
    .deleted_mark_seen(p[1]),
    .data_mark_timeout(p[0]),
    .wp_force(wp_force),
    .write_protect_input(write_protect_input),
    .outer_track_input(outer_track_input),
    .index_pulse_input(index_pulse_input),
    .terminal_count_input(terminal_count_input),
    .side_select_output(side_select_output),
    .drive_select_output(drive_select_output),
    .result_read(p[12]),
    .result_data(result_data),
    .result_valid(result_valid),
    .transfer_error_status(transfer_error_status),
    .address_mark_status(address_mark_status)
  );
  drive_model drive_model_i (
    .clk_sys(clk_sys),
    .spin(spin),
    .wp_level(wp_level),
    .trk_level(trk_level),
    .write_protect_input(write_protect_input),
    .outer_track_input(outer_track_input),
    .index_pulse_input(index_pulse_input)
  );

  task automatic fire(input logic [15:0] v);
    p <= v;
    @(posedge clk_sys);
    p <= 16'h0000;
    @(posedge clk_sys);
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic rd(input logic [7:0] exp);
    @(negedge clk_sys);
    chk(result_data, exp);
    chk({7'h00, result_valid}, 8'h01);
    @(posedge clk_sys);
    fire(16'h1000);
  endtask

  // Pins settle first: the 2-FF sync hides changes for a few clocks
  task automatic run(input cmd_class_type c, input logic [15:0] ev, input logic [1:0] tc_idx,
      input logic [7:0] cfg, input logic [7:0] te, input logic [7:0] am, input logic [7:0] dl);
    wp_force <= cfg[7:6];
    wp_level <= cfg[5];
    trk_level <= cfg[3];
    side_select_output <= cfg[2];
    drive_select_output <= cfg[1:0];
    repeat (4) @(posedge clk_sys);
    cmd_class <= c;
    fire(16'h8000);
    wp_level <= cfg[4];
    terminal_count_input <= tc_idx[1];
    spin <= tc_idx[0];
    fire(ev);
    repeat (tc_idx[0] ? 40 : 4) @(posedge clk_sys);
    terminal_count_input <= 1'b0;
    spin <= 1'b0;
    fire(16'h4000);
    rd(te);
    rd(am);
    rd(dl);
    rd(dl);
    fire(16'h2000);
    @(negedge clk_sys);
    chk(result_data | {7'h00, result_valid}, 8'h00);
    chk(transfer_error_status, te);
    chk(address_mark_status, am);
    @(posedge clk_sys);
  endtask

  task automatic tally_and_finish();
    if (bad_count == 0 && check_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  initial begin
    repeat (5) @(posedge clk_sys);
    reset_n <= 1'b1;
    @(negedge clk_sys);
    chk(result_data | transfer_error_status | address_mark_status, 8'h00);
    @(posedge clk_sys);
    sector_number <= 8'hff;
    id_track <= 8'hff;
    run(CMD_READ_DATA, 16'h0ae3, 2'h0, 8'h0e, 8'hb5, 8'h73, 8'h3e);
    sector_number <= 8'h01;
    id_track <= 8'h03;
    run(CMD_WRITE_DATA, 16'h0100, 2'h2, 8'h11, 8'h22, 8'h00, 8'h69);
    run(CMD_WRITE_DELETED, 16'h0000, 2'h2, 8'h11, 8'h02, 8'h00, 8'h69);
    run(CMD_FORMAT, 16'h0000, 2'h2, 8'h11, 8'h02, 8'h00, 8'h69);
    run(CMD_READ_ID, 16'h0810, 2'h2, 8'h48, 8'h04, 8'h00, 8'h78);
    id_track <= 8'h05;
    internal_track <= 8'h06;
    run(CMD_READ_TRACK, 16'h0808, 2'h3, 8'hb7, 8'h05, 8'h10, 8'h2f);
    run(CMD_READ_DELETED, 16'h0004, 2'h2, 8'hf9, 8'h00, 8'h40, 8'h79);
    tally_and_finish();
  end

  // Whole run needs well under 600 clocks
  initial begin
    repeat (3000) @(posedge clk_sys);
    bad_count++;
    tally_and_finish();
  end
endmodule // tb_top
